// [bench/strap_host_model.sv]
module strap_host_model
	import amp_strap_pkg::*;
#(
	parameter int SAMPLE_HZ = SAMPLE_HZ_DEF
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic want_power,
	input wire logic want_quiet,
	input wire logic swap_lr,
	output logic amp_quiet_pin,
	output logic amp_power_down_pin_n,
	output logic [15:0] audio_left,
	output logic [15:0] audio_right,
	output logic audio_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DIV = CLOCK_HZ / SAMPLE_HZ;
	localparam logic [15:0] TONE_L = 16'h2000;
	localparam logic [15:0] TONE_R = 16'hE000;
	int cnt_ff;
	logic [15:0] slot_r;
	logic last;
	// wanted content moved into the right slot
	assign slot_r = swap_lr ? TONE_L : TONE_R;
	assign last = (cnt_ff == DIV - 1);
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_ff <= 0;
			amp_quiet_pin <= 1'b0;
			amp_power_down_pin_n <= 1'b0;
			audio_valid <= 1'b0;
			audio_left <= 16'h0000;
			audio_right <= 16'h0000;
		end else begin
			// quiet leads power-down by a cycle
			amp_quiet_pin <= want_quiet | ~want_power;
			if (want_power)
				amp_power_down_pin_n <= 1'b1;
			else if (amp_quiet_pin)
				amp_power_down_pin_n <= 1'b0;
			cnt_ff <= last ? 0 : cnt_ff + 1;
			audio_valid <= last;
			// data lines hold inverted words outside the valid cycle
			audio_left <= last ? TONE_L : ~TONE_L;
			audio_right <= last ? slot_r : ~slot_r;
		end
	end
endmodule // strap_host_model

// [bench/tb.sv]
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import amp_strap_pkg::*;
	logic clock, sys_rst, rate, par, want_power, want_quiet, swap_lr;
	logic quiet, pwr_n, av, reg_wr, reg_rd;
	logic [1:0] gain;
	logic [15:0] al, ar;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata_ff;
	logic pwm_left_ff, pwm_right_ff, stage_enable_ff, path_active_ff;
	logic software_mode_ff, parallel_bridge_mode_ff, fast_switch_ff;
	logic [7:0] analog_gain_ff, digital_boost_ff, volume_ff;
	logic [7:0] gain_tab [4] = '{AGAIN_LOW, AGAIN_MID, AGAIN_HIGH, AGAIN_NONE};
	int fail_count = 0;
	int checks_done = 0;
	int cycles = 0;

	amp_hw_strap_config dut_u (.clock(clock), .sys_rst(sys_rst),
		.switch_rate_select_pin(rate), .parallel_load_select_pin(par),
		.amp_quiet_pin(quiet), .amp_gain_select_pins(gain),
		.amp_power_down_pin_n(pwr_n), .serial_audio_in_left(al),
		.serial_audio_in_right(ar), .serial_audio_in_valid(av),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
		.pwm_left_ff(pwm_left_ff), .pwm_right_ff(pwm_right_ff),
		.stage_enable_ff(stage_enable_ff), .path_active_ff(path_active_ff),
		.software_mode_ff(software_mode_ff),
		.parallel_bridge_mode_ff(parallel_bridge_mode_ff),
		.fast_switch_ff(fast_switch_ff), .analog_gain_ff(analog_gain_ff),
		.digital_boost_ff(digital_boost_ff), .volume_ff(volume_ff));
	strap_host_model host_u (.clock(clock), .sys_rst(sys_rst),
		.want_power(want_power), .want_quiet(want_quiet),
		.swap_lr(swap_lr), .amp_quiet_pin(quiet),
		.amp_power_down_pin_n(pwr_n), .audio_left(al), .audio_right(ar),
		.audio_valid(av));

	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("BAD %s expected %0h seen %0h", name, exp, got);
			fail_count++;
		end
	endtask

	task automatic rd(logic [3:0] a, output logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata_ff;
	endtask

	task automatic wr(logic [3:0] a, logic [31:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task automatic wait_stage(logic lvl, int lim);
		for (int n = 0; n < lim && stage_enable_ff !== lvl; n++)
			@(posedge clock);
		#1 chk("stage_enable", lvl, stage_enable_ff);
	endtask

	task automatic period(int exp);
		realtime t0;
		int n;
		@(posedge pwm_left_ff);
		t0 = $realtime;
		@(posedge pwm_left_ff);
		n = int'(($realtime - t0) / 10.0);
		chk("period_near", 1, n >= exp - 2 && n <= exp + 2);
	endtask

	task automatic sample_wait;
		repeat (2) @(posedge clock);
		do
			@(posedge clock);
		while (av !== 1'b1);
		// one carrier wrap moves the new sample into the duty
		repeat (300) @(posedge clock);
	endtask

	task automatic swap_test;
		int highs;
		for (int s = 0; s < 2; s++) begin
			@(posedge clock);
			swap_lr <= s[0];
			sample_wait;
			highs = 0;
			repeat (1310) begin
				@(posedge clock);
				#1 highs += int'(pwm_left_ff === 1'b1);
			end
			// both outputs play the right slot; only the left tone is positive
			chk("right_slot", s[0], highs > 655);
		end
	endtask

	task automatic apply(logic r, logic p, logic [1:0] g);
		want_power <= 1'b0;
		repeat (8) @(posedge clock);
		rate <= r;
		par <= p;
		gain <= g;
		repeat (4) @(posedge clock);
		want_power <= 1'b1;
		repeat (8) @(posedge clock);
	endtask

	task automatic reg_test;
		logic [31:0] d;
		#1 chk("fast_rst", 1, fast_switch_ff);
		chk("gain_rst", AGAIN_LOW, analog_gain_ff);
		chk("path_rst", 0, path_active_ff);
		wr(REG_RAMP, 32'h0000_00FF);
		rd(REG_RAMP, d);
		chk("ramp", 32'h0000_00FF, d);
		wr(REG_GAIN, 32'h0000_0000);
		rd(REG_GAIN, d);
		chk("gain_reg", {8'h00, VOLUME_DB, BOOST_DB, AGAIN_LOW}, d);
		rd(4'hC, d);
		chk("unmapped", 0, d);
	endtask

	task automatic config_test(int i);
		logic [31:0] s;
		logic [4:0] exp_st;
		int diff;
		int per;
		diff = 0;
		apply(i[0], i[1], i[1:0]);
		wait_stage(i != 3, 20);
		chk("software", i == 3, software_mode_ff);
		chk("fast", !i[0], fast_switch_ff);
		// in software mode the parallel pin serves the control port
		chk("parallel", i == 2, parallel_bridge_mode_ff);
		chk("analog", gain_tab[i], analog_gain_ff);
		chk("boost", BOOST_DB, digital_boost_ff);
		chk("volume", VOLUME_DB, volume_ff);
		rd(REG_STATUS, s);
		exp_st = {i == 3, i == 2, !i[0], i[1:0]};
		chk("status", exp_st, {s[6:4], s[1:0]});
		if (i == 3)
			return;
		sample_wait;
		per = CLOCK_HZ / ((i[0] ? FS_MULT_SLOW : FS_MULT_FAST) * SAMPLE_HZ_DEF);
		period(per);
		repeat (300) begin
			@(posedge clock);
			#1 diff += int'(pwm_left_ff !== pwm_right_ff);
		end
		chk("outputs_differ", !i[1], diff != 0);
	endtask

	task automatic sleep_test;
		want_quiet <= 1'b1;
		wait_stage(0, 2000);
		chk("path_sleep", 1, path_active_ff);
		chk("pwm_idle", 0, {pwm_left_ff, pwm_right_ff});
		// strap change while asleep must be ignored
		rate <= 1'b1;
		gain <= 2'h0;
		repeat (20) @(posedge clock);
		want_quiet <= 1'b0;
		wait_stage(1, 20);
		chk("gain_kept", AGAIN_HIGH, analog_gain_ff);
		chk("fast_kept", 1, fast_switch_ff);
		chk("par_kept", 1, parallel_bridge_mode_ff);
	endtask

	task automatic shutdown_test;
		want_power <= 1'b0;
		repeat (8) @(posedge clock);
		#1 chk("path_off", 0, path_active_ff);
		chk("stage_off", 0, stage_enable_ff);
	endtask

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 40000) begin
			fail_count++;
			conclude;
		end
	end

	initial begin
		sys_rst = 1'b1;
		{rate, par, gain, want_power, want_quiet, swap_lr} = '0;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		reg_test;
		for (int i = 0; i < 3; i++)
			config_test(i);
		swap_test;
		sleep_test;
		shutdown_test;
		config_test(3);
		conclude;
	end
endmodule // tb

// [core/amp_hw_strap_config.sv]
// How it works
// [R1] rate pin low: switch at 16x sample rate
// [R2] rate pin high: switch at 8x sample rate
// [R3] parallel pin high: parallel bridge mode
// [R4] parallel pin low: two-channel bridge mode
// [R5] parallel mode plays the right-channel slot
// [R6] sender inverts word select for left content
// [R7] quiet pin high: ramp down, then high-Z
// [R8] signal path keeps running while quiet
// [R9] sender asserts quiet before stopping audio
// [R10] gain codes 00..10 pick rising analog gain
// [R11] analog gain 19.2, 22.6, 25 dBV
// [R12] gain code 11 hands control to software
// [R13] digital boost fixed at +6 dB
// [R14] volume stays at unity gain
// [R15] power-down pin low: lowest-power shutdown
// [R16] sender asserts quiet before power-down
// [R17] straps are static during operation
// [R18] quiet release resumes with same configuration
//
// The register offsets and the plain strobed port were chosen for this implementation.
module amp_hw_strap_config #(
	parameter int SAMPLE_HZ = amp_strap_pkg::SAMPLE_HZ_DEF,
	parameter int DATA_W = 16
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic switch_rate_select_pin,
	input wire logic parallel_load_select_pin,
	input wire logic amp_quiet_pin,
	input wire logic [1:0] amp_gain_select_pins,
	input wire logic amp_power_down_pin_n,
	input wire logic [DATA_W-1:0] serial_audio_in_left,
	input wire logic [DATA_W-1:0] serial_audio_in_right,
	input wire logic serial_audio_in_valid,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata_ff,
	output logic pwm_left_ff,
	output logic pwm_right_ff,
	output logic stage_enable_ff,
	output logic path_active_ff,
	output logic software_mode_ff,
	output logic parallel_bridge_mode_ff,
	output logic fast_switch_ff,
	output logic [7:0] analog_gain_ff,
	output logic [7:0] digital_boost_ff,
	output logic [7:0] volume_ff
);
	import amp_strap_pkg::*;

	localparam logic [15:0] STEP_FAST =
		16'((64'd65536 * FS_MULT_FAST * SAMPLE_HZ) / CLOCK_HZ);
	localparam logic [15:0] STEP_SLOW =
		16'((64'd65536 * FS_MULT_SLOW * SAMPLE_HZ) / CLOCK_HZ);

	function automatic logic [7:0] gain_decode(input logic [1:0] code);
		logic [7:0] g;
		g = AGAIN_NONE;
		if (code == GAIN_LOW) begin
			g = AGAIN_LOW;
		end else if (code == GAIN_MID) begin
			g = AGAIN_MID;
		end else if (code == GAIN_HIGH) begin
			g = AGAIN_HIGH;
		end
		return g;
	endfunction

	function automatic logic [15:0] boost_sat(input logic [15:0] s);
		logic [15:0] r;
		r = {s[14:0], 1'b0};
		if (s[15] != s[14]) begin
			r = s[15] ? 16'h8000 : 16'h7FFF;
		end
		return r;
	endfunction

	// two-stage synchronisers for the strap and control pins
	logic [PIN_COUNT-1:0] pin_raw;
	logic [PIN_COUNT-1:0] pin_q1_ff;
	logic [PIN_COUNT-1:0] pin_q2_ff;
	assign pin_raw = {amp_power_down_pin_n, amp_gain_select_pins,
		amp_quiet_pin, parallel_load_select_pin, switch_rate_select_pin};
	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
			always_ff @(posedge clock or posedge sys_rst) begin
				if (sys_rst) begin
					pin_q1_ff[gi] <= 1'b0;
					pin_q2_ff[gi] <= 1'b0;
				end else begin
					pin_q1_ff[gi] <= pin_raw[gi];
					pin_q2_ff[gi] <= pin_q1_ff[gi];
				end
			end
		end
	endgenerate

	logic quiet_req;
	logic power_on;
	logic [1:0] gain_pins;
	assign quiet_req = pin_q2_ff[PIN_QUIET];
	assign power_on = pin_q2_ff[PIN_PWR_N];
	assign gain_pins = {pin_q2_ff[PIN_GAIN1], pin_q2_ff[PIN_GAIN0]};

	amp_state_type state_ff, nxt_state;
	logic [7:0] level_ff, nxt_level;
	logic [15:0] phase_ff, nxt_phase;
	logic [15:0] hold_left_ff, nxt_hold_left;
	logic [15:0] hold_right_ff, nxt_hold_right;
	logic [15:0] duty_left_ff, nxt_duty_left;
	logic [15:0] duty_right_ff, nxt_duty_right;
	logic [7:0] ramp_step_ff, nxt_ramp_step;
	logic [1:0] gain_code_ff, nxt_gain_code;
	logic nxt_parallel, nxt_fast, nxt_software;
	logic [7:0] nxt_analog;
	logic nxt_pwm_left, nxt_pwm_right, nxt_stage, nxt_path;
	logic [31:0] nxt_rdata;
	logic [16:0] phase_sum;
	logic wrap;
	logic [15:0] step_sel;
	logic [7:0] step_eff;
	logic [15:0] src_left, src_right;
	logic signed [24:0] prod_left, prod_right;

	// carrier phase: one wrap per switching period
	always_comb begin
		step_sel = fast_switch_ff ? STEP_FAST : STEP_SLOW; // see [R1] [R2]
		phase_sum = {1'b0, phase_ff} + {1'b0, step_sel};
		wrap = phase_sum[16];
		nxt_phase = (state_ff == ST_OFF) ? 16'h0000 : phase_sum[15:0];
	end

	// configuration follows the straps only while shut down
	always_comb begin
		nxt_gain_code = gain_code_ff;
		nxt_parallel = parallel_bridge_mode_ff;
		nxt_fast = fast_switch_ff;
		nxt_software = software_mode_ff;
		nxt_analog = analog_gain_ff;
		if (state_ff == ST_OFF) begin
			nxt_gain_code = gain_pins;
			nxt_software = (gain_pins == GAIN_SOFTWARE); // see [R12]
			// rate and parallel pins belong to the control port then
			nxt_parallel = !nxt_software && pin_q2_ff[PIN_PAR]; // see [R3] [R4]
			nxt_fast = !nxt_software && !pin_q2_ff[PIN_RATE]; // see [R1] [R2]
			nxt_analog = gain_decode(gain_pins); // see [R10] [R11]
		end
	end

	// level ramp and power state
	always_comb begin
		nxt_state = state_ff;
		nxt_level = level_ff;
		step_eff = (ramp_step_ff == RAMP_ZERO) ? 8'h01 : ramp_step_ff;
		case (state_ff)
			ST_OFF: begin
				nxt_level = RAMP_ZERO;
				if (power_on && gain_pins != GAIN_SOFTWARE) begin
					nxt_state = quiet_req ? ST_QUIET : ST_RAMP_UP;
				end
			end
			ST_RUN: begin
				if (quiet_req) begin
					nxt_state = ST_RAMP_DN; // see [R7]
				end
			end
			ST_RAMP_DN: begin
				if (!quiet_req) begin
					nxt_state = ST_RAMP_UP;
				end else if (wrap) begin
					if (level_ff > step_eff) begin
						nxt_level = level_ff - step_eff;
					end else begin
						nxt_level = RAMP_ZERO;
						nxt_state = ST_QUIET; // see [R7]
					end
				end
			end
			ST_QUIET: begin
				if (!quiet_req) begin
					nxt_state = ST_RAMP_UP; // see [R18]
				end
			end
			ST_RAMP_UP: begin
				if (quiet_req) begin
					nxt_state = ST_RAMP_DN;
				end else if (wrap) begin
					if (RAMP_FULL - level_ff > step_eff) begin
						nxt_level = level_ff + step_eff;
					end else begin
						nxt_level = RAMP_FULL;
						nxt_state = ST_RUN;
					end
				end
			end
			default: begin
				nxt_state = ST_OFF;
			end
		endcase
		if (!power_on) begin
			nxt_state = ST_OFF; // see [R15]
			nxt_level = RAMP_ZERO;
		end
	end

	// signal path: unity volume, fixed boost, level scaling
	always_comb begin
		nxt_hold_left = hold_left_ff;
		nxt_hold_right = hold_right_ff;
		if (serial_audio_in_valid && state_ff != ST_OFF) begin // see [R8]
			nxt_hold_left = serial_audio_in_left[DATA_W-1 -: 16];
			nxt_hold_right = serial_audio_in_right[DATA_W-1 -: 16];
		end
		// volume at unity: samples go straight to the boost
		src_right = boost_sat(hold_right_ff); // see [R13] [R14]
		src_left = parallel_bridge_mode_ff ? src_right
			: boost_sat(hold_left_ff); // see [R5]
		// 16 x 9 bit product fits the 25-bit result without overflow
		prod_left = $signed(src_left) * $signed({1'b0, level_ff});
		prod_right = $signed(src_right) * $signed({1'b0, level_ff});
		nxt_duty_left = duty_left_ff;
		nxt_duty_right = duty_right_ff;
		if (wrap) begin
			nxt_duty_left = prod_left[23:8] ^ MID_SCALE;
			nxt_duty_right = prod_right[23:8] ^ MID_SCALE;
		end
	end

	// output stage: switching only while not quiet and not off
	always_comb begin
		nxt_stage = (nxt_state == ST_RUN) || (nxt_state == ST_RAMP_DN)
			|| (nxt_state == ST_RAMP_UP); // see [R7]
		nxt_path = (nxt_state != ST_OFF); // see [R8] [R15]
		nxt_pwm_left = nxt_stage && (nxt_phase < nxt_duty_left);
		nxt_pwm_right = nxt_stage && (nxt_phase < nxt_duty_right);
	end

	// register port
	always_comb begin
		nxt_ramp_step = ramp_step_ff;
		if (reg_wr && reg_addr == REG_RAMP) begin
			nxt_ramp_step = reg_wdata[7:0];
		end
		nxt_rdata = 32'h00000000;
		if (reg_rd && reg_addr == REG_STATUS) begin
			nxt_rdata = {19'h00000, state_ff, path_active_ff,
				software_mode_ff, parallel_bridge_mode_ff, fast_switch_ff,
				2'h0, gain_code_ff};
		end else if (reg_rd && reg_addr == REG_RAMP) begin
			nxt_rdata = {24'h000000, ramp_step_ff};
		end else if (reg_rd && reg_addr == REG_GAIN) begin
			nxt_rdata = {8'h00, volume_ff, digital_boost_ff, analog_gain_ff};
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_ff <= ST_OFF;
			level_ff <= RAMP_ZERO;
			phase_ff <= 16'h0000;
			hold_left_ff <= 16'h0000;
			hold_right_ff <= 16'h0000;
			duty_left_ff <= MID_SCALE;
			duty_right_ff <= MID_SCALE;
			ramp_step_ff <= RAMP_STEP_RST;
			gain_code_ff <= GAIN_LOW;
			parallel_bridge_mode_ff <= 1'b0;
			fast_switch_ff <= 1'b1;
			software_mode_ff <= 1'b0;
			analog_gain_ff <= AGAIN_LOW;
			digital_boost_ff <= BOOST_DB;
			volume_ff <= VOLUME_DB;
			pwm_left_ff <= 1'b0;
			pwm_right_ff <= 1'b0;
			stage_enable_ff <= 1'b0;
			path_active_ff <= 1'b0;
			reg_rdata_ff <= 32'h00000000;
		end else begin
			state_ff <= nxt_state;
			level_ff <= nxt_level;
			phase_ff <= nxt_phase;
			hold_left_ff <= nxt_hold_left;
			hold_right_ff <= nxt_hold_right;
			duty_left_ff <= nxt_duty_left;
			duty_right_ff <= nxt_duty_right;
			ramp_step_ff <= nxt_ramp_step;
			gain_code_ff <= nxt_gain_code;
			parallel_bridge_mode_ff <= nxt_parallel;
			fast_switch_ff <= nxt_fast;
			software_mode_ff <= nxt_software;
			analog_gain_ff <= nxt_analog;
			digital_boost_ff <= BOOST_DB; // see [R13]
			volume_ff <= VOLUME_DB; // see [R14]
			pwm_left_ff <= nxt_pwm_left;
			pwm_right_ff <= nxt_pwm_right;
			stage_enable_ff <= nxt_stage;
			path_active_ff <= nxt_path;
			reg_rdata_ff <= nxt_rdata;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	sequence sd_request;
		!power_on;
	endsequence
	sequence sd_reached;
		state_ff == ST_OFF && !stage_enable_ff && !path_active_ff;
	endsequence
	sequence quiet_release;
		state_ff == ST_QUIET && !quiet_req && power_on;
	endsequence
	sequence resumed_same;
		state_ff == ST_RAMP_UP && $stable(analog_gain_ff)
			&& $stable(parallel_bridge_mode_ff) && $stable(fast_switch_ff);
	endsequence

	chk_rate_fast: assert property ( // see [R1]
		state_ff == ST_OFF && !software_mode_ff && gain_pins != GAIN_SOFTWARE
		&& !pin_q2_ff[PIN_RATE] |=> fast_switch_ff && step_sel == STEP_FAST)
		else $error("low rate pin did not select 16x");
	chk_rate_slow: assert property ( // see [R2]
		state_ff == ST_OFF && gain_pins != GAIN_SOFTWARE
		&& pin_q2_ff[PIN_RATE] |=> !fast_switch_ff && step_sel == STEP_SLOW)
		else $error("high rate pin did not select 8x");
	chk_bridge_pin: assert property ( // see [R3] [R4]
		state_ff == ST_OFF && gain_pins != GAIN_SOFTWARE
		|=> parallel_bridge_mode_ff == $past(pin_q2_ff[PIN_PAR]))
		else $error("bridge mode does not follow its pin");
	chk_parallel_src: assert property ( // see [R5]
		wrap && parallel_bridge_mode_ff |=> duty_left_ff == duty_right_ff)
		else $error("parallel mode outputs differ");
	chk_quiet_hiz: assert property ( // see [R7]
		state_ff == ST_QUIET |-> !stage_enable_ff && !pwm_left_ff
		&& !pwm_right_ff)
		else $error("stage switching while quiet");
	chk_quiet_ramp: assert property ( // see [R7]
		state_ff == ST_RUN && quiet_req && power_on |=> state_ff == ST_RAMP_DN
		&& stage_enable_ff)
		else $error("quiet did not start a ramp");
	chk_quiet_path: assert property ( // see [R8]
		state_ff == ST_QUIET |-> path_active_ff)
		else $error("signal path stopped while quiet");
	chk_gain_mid: assert property ( // see [R10] [R11]
		state_ff != ST_OFF && gain_code_ff == GAIN_MID
		|-> analog_gain_ff == AGAIN_MID)
		else $error("gain code 01 not 22.6 dBV");
	chk_gain_high: assert property ( // see [R11]
		state_ff != ST_OFF && gain_code_ff == GAIN_HIGH
		|-> analog_gain_ff == AGAIN_HIGH)
		else $error("gain code 10 not 25 dBV");
	chk_soft_hand: assert property ( // see [R12]
		state_ff == ST_OFF && gain_pins == GAIN_SOFTWARE
		|=> software_mode_ff && state_ff == ST_OFF && !fast_switch_ff)
		else $error("gain code 11 did not hand over");
	chk_fixed_gain: assert property ( // see [R13] [R14]
		path_active_ff |-> digital_boost_ff == BOOST_DB
		&& volume_ff == VOLUME_DB)
		else $error("boost or volume moved");
	chk_power_down: assert property ( // see [R15]
		sd_request |=> sd_reached)
		else $error("shutdown not reached in one cycle");
	chk_quiet_resume: assert property ( // see [R18]
		quiet_release |=> resumed_same)
		else $error("resume changed configuration");
endmodule // amp_hw_strap_config

// [core/amp_strap_pkg.sv]
package amp_strap_pkg;
	localparam int CLOCK_HZ = 100_000_000;
	localparam int SAMPLE_HZ_DEF = 48_000;
	localparam int FS_MULT_FAST = 16;
	localparam int FS_MULT_SLOW = 8;
	localparam int PIN_COUNT = 6;
	localparam int PIN_RATE = 0;
	localparam int PIN_PAR = 1;
	localparam int PIN_QUIET = 2;
	localparam int PIN_GAIN0 = 3;
	localparam int PIN_GAIN1 = 4;
	localparam int PIN_PWR_N = 5;
	localparam logic [1:0] GAIN_LOW = 2'h0;
	localparam logic [1:0] GAIN_MID = 2'h1;
	localparam logic [1:0] GAIN_HIGH = 2'h2;
	localparam logic [1:0] GAIN_SOFTWARE = 2'h3;
	// analog gain in tenths of a dBV: 19.2, 22.6, 25.0
	localparam logic [7:0] AGAIN_LOW = 8'hC0;
	localparam logic [7:0] AGAIN_MID = 8'hE2;
	localparam logic [7:0] AGAIN_HIGH = 8'hFA;
	localparam logic [7:0] AGAIN_NONE = 8'h00;
	localparam logic [7:0] BOOST_DB = 8'h06;
	localparam logic [7:0] VOLUME_DB = 8'h00;
	localparam logic [7:0] RAMP_FULL = 8'hFF;
	localparam logic [7:0] RAMP_ZERO = 8'h00;
	localparam logic [7:0] RAMP_STEP_RST = 8'h04;
	localparam logic [15:0] MID_SCALE = 16'h8000;
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_RAMP = 4'h4;
	localparam logic [3:0] REG_GAIN = 4'h8;
	typedef enum logic [4:0] {
		ST_OFF = 5'b00001,
		ST_RUN = 5'b00010,
		ST_RAMP_DN = 5'b00100,
		ST_QUIET = 5'b01000,
		ST_RAMP_UP = 5'b10000
	} amp_state_type;
endpackage
